/* pkg/scf_pkg.sv */
// constants, types and register map of the shift, clear and field datapath
package scf_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] SCF_CMD_OFF = 8'h00;
  localparam logic [7:0] SCF_STAT_OFF = 8'h04;
  localparam logic [7:0] SCF_PRIM_OFF = 8'h08;
  localparam logic [7:0] SCF_SEC_OFF = 8'h0c;
  localparam logic [7:0] SCF_EXT_OFF = 8'h10;
  localparam logic [7:0] SCF_OPND_OFF = 8'h14;
  localparam logic [7:0] SCF_GR_BASE = 8'h20;
  localparam logic [7:0] SCF_FLD_BASE = 8'h40;
  localparam logic [7:0] SCF_MEM_BASE = 8'h80;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] SCF_WORD_RST = 32'h0000_0000;
  localparam logic [63:0] SCF_FLD_RST = 64'h0000_0000_0000_0000;

  // ----------------------------------------------------------------------
  // status fields
  // ----------------------------------------------------------------------
  localparam int SCF_STAT_CARRY = 0;
  localparam int SCF_STAT_LINK = 1;
  localparam int SCF_STAT_EXC = 2;

  // ----------------------------------------------------------------------
  // field address and length register layout (bit 1 is the msb, bit 63)
  // ----------------------------------------------------------------------
  localparam int SCF_RING_HI = 62;
  localparam int SCF_RING_LO = 61;
  localparam int SCF_SEG_HI = 59;
  localparam int SCF_SEG_LO = 48;
  localparam int SCF_OFS_HI = 47;
  localparam int SCF_OFS_LO = 32;
  localparam int SCF_BIT_HI = 31;
  localparam int SCF_BIT_LO = 28;
  localparam int SCF_MBZ_HI = 27;
  localparam int SCF_MBZ_LO = 21;
  localparam int SCF_LEN_HI = 20;
  localparam int SCF_LEN_LO = 0;
  localparam int SCF_LEN_W = 21;
  // bits that software may hold; bit 1, bit 4 and bits 37-43 stay zero
  localparam logic [63:0] SCF_FLD_MASK = 64'h6fff_ffff_f01f_ffff;

  // ----------------------------------------------------------------------
  // commands
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SH_LOGIC,
    SH_ARITH,
    SH_ROT,
    SH_SPARE
  } scf_shift_e;

  typedef enum logic [5:0] {
    OP_NOP,
    OP_SHIFT,
    OP_CLEAR_PRIMARY_HIGH_BYTE,
    OP_CLEAR_PRIMARY_LOW_BYTE,
    OP_ZERO_WHOLE_REGISTER,
    OP_ZERO_PRIMARY_ACC,
    OP_ZERO_SECONDARY_REG,
    OP_ZERO_REG_TOP_BYTE,
    OP_ZERO_REG_SECOND_BYTE,
    OP_ZERO_EXTENSION_REG,
    OP_ZERO_UPPER_HALFWORD,
    OP_ZERO_LOWER_HALFWORD,
    OP_ZERO_LONG_ACC,
    OP_ZERO_LONG_AND_EXTENSION,
    OP_ZERO_MEMORY_WORD,
    OP_ZERO_MEMORY_HALF,
    OP_ADD_LONG_TO_FIELD_ADDRESS,
    OP_ADD_REG_TO_FIELD_ADDRESS,
    OP_EFF_ADDR_TO_FIELD_ADDRESS,
    OP_LOAD_CHAR_FROM_FIELD,
    OP_LOAD_LENGTH_IMMEDIATE,
    OP_STORE_FIELD_ADDRESS,
    OP_STORE_CHAR_TO_FIELD,
    OP_LENGTH_TO_LONG_ACC,
    OP_LONG_ACC_TO_LENGTH,
    OP_LENGTH_TO_GENERAL_REG,
    OP_GENERAL_REG_TO_LENGTH
  } scf_op_e;

  // command word as written to the command register
  typedef struct packed {
    logic [6:0] rsv3;
    logic [4:0] cnt;
    logic [1:0] rsv2;
    scf_shift_e kind;
    logic left;
    logic tgt_long;
    logic half_low;
    logic fsel;
    logic rsv1;
    logic [2:0] rsel;
    logic [1:0] rsv0;
    scf_op_e op;
  } scf_cmd_s;

endpackage

/* rtl/scf_shifter.sv */
// barrel of single-bit steps for logical, arithmetic and rotate shifts
`timescale 1ns/100ps
module scf_shifter #(
  parameter int W = 32
) (
  input wire logic [W-1:0] val,
  input wire logic [4:0] cnt,
  input wire logic left,
  input wire scf_pkg::scf_shift_e kind,
  output logic [W-1:0] res,
  output logic last,
  output logic ovf
);
  import scf_pkg::*;

  always_comb begin
    res = val;
    last = 1'b0;
    ovf = 1'b0;
    for (int i = 0; i < W; i++) begin
      if (i < int'(cnt)) begin
        if (left) begin
          last = res[W-1];
          if (kind == SH_ARITH && res[W-1] != res[W-2]) begin
            ovf = 1'b1;
          end
          if (kind == SH_ROT) begin
            res = {res[W-2:0], res[W-1]};
          end else begin
            res = {res[W-2:0], 1'b0};
          end
        end else begin
          last = res[0];
          case (kind)
            SH_ROT: res = {res[0], res[W-1:1]};
            SH_ARITH: res = {res[W-1], res[W-1:1]};
            default: res = {1'b0, res[W-1:1]};
          endcase
        end
      end
    end
  end
endmodule

/* rtl/scf_datapath.sv */
// shift, clear and field register datapath with an apb register slave
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module scf_datapath #(
  parameter int MEM_WORDS = 16,
  parameter int NUM_GR = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic carry_bit,
  output logic link_bit,
  output logic int_exception
);
  import scf_pkg::*;

  localparam int MW = $clog2(MEM_WORDS);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic carry_q;
  logic link_q;
  logic exc_q;
  logic exc_pulse_q;
  logic [31:0] cmd_q;
  logic [15:0] prim_q;
  logic [15:0] sec_q;
  logic [31:0] ext_q;
  logic [31:0] opnd_q;
  logic [31:0] gr_q [NUM_GR];
  logic [63:0] fld_q [2];
  logic [31:0] mem_q [MEM_WORDS];

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  logic acc;
  logic done;
  logic wr_done;
  logic hit;
  logic [31:0] rdata_d;
  logic exec;
  scf_cmd_s cmd;

  assign acc = psel & penable;
  assign done = acc & pready_q;
  assign wr_done = done & pwrite;
  assign exec = wr_done && paddr == SCF_CMD_OFF;
  assign cmd = scf_cmd_s'(pwdata);

  always_comb begin
    hit = 1'b1;
    rdata_d = 32'h0000_0000;
    if (paddr == SCF_CMD_OFF) begin
      rdata_d = cmd_q;
    end else if (paddr == SCF_STAT_OFF) begin
      rdata_d[SCF_STAT_CARRY] = carry_q;
      rdata_d[SCF_STAT_LINK] = link_q;
      rdata_d[SCF_STAT_EXC] = exc_q;
    end else if (paddr == SCF_PRIM_OFF) begin
      rdata_d = {16'h0000, prim_q};
    end else if (paddr == SCF_SEC_OFF) begin
      rdata_d = {16'h0000, sec_q};
    end else if (paddr == SCF_EXT_OFF) begin
      rdata_d = ext_q;
    end else if (paddr == SCF_OPND_OFF) begin
      rdata_d = opnd_q;
    end else if (paddr[7:5] == SCF_GR_BASE[7:5]) begin
      rdata_d = gr_q[paddr[4:2]];
    end else if (paddr[7:4] == SCF_FLD_BASE[7:4]) begin
      rdata_d = paddr[2] ? fld_q[paddr[3]][31:0] : fld_q[paddr[3]][63:32];
    end else if (paddr[7] && 32'(paddr[6:2]) < MEM_WORDS) begin
      rdata_d = mem_q[paddr[MW+1:2]];
    end else begin
      hit = 1'b0;
    end
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= acc & ~pready_q;
      pslverr_q <= acc & ~pready_q & ~hit;
    end
  end

  // read data loaded once per transfer, zero for writes and misses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= SCF_WORD_RST;
    end else if (acc && !pready_q) begin
      prdata_q <= (pwrite || !hit) ? 32'h0000_0000 : rdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // shifter
  // ----------------------------------------------------------------------
  logic [31:0] sh_src;
  logic [31:0] sh_res;
  logic sh_last;
  logic sh_ovf;
  logic do_shift;

  assign sh_src = cmd.tgt_long ? {prim_q, sec_q} : gr_q[cmd.rsel];
  assign do_shift = exec && cmd.op == OP_SHIFT && cmd.cnt != 5'h00;

  scf_shifter #(
    .W(32)
  ) u_shifter (
    .val(sh_src),
    .cnt(cmd.cnt),
    .left(cmd.left),
    .kind(cmd.kind),
    .res(sh_res),
    .last(sh_last),
    .ovf(sh_ovf)
  );

  // ----------------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------------
  logic exc_set;
  logic stat_wr;
  assign exc_set = do_shift && cmd.left && cmd.kind == SH_ARITH && sh_ovf;
  assign stat_wr = wr_done && paddr == SCF_STAT_OFF;

  // carry and link move only on a shift or a status write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_q <= 1'b0;
      link_q <= 1'b0;
    end else if (do_shift) begin
      carry_q <= sh_last;
      link_q <= sh_last;
    end else if (stat_wr) begin
      carry_q <= pwdata[SCF_STAT_CARRY];
      link_q <= pwdata[SCF_STAT_LINK];
    end
  end

  // sticky exception: a new overflow wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_q <= 1'b0;
    end else if (exc_set) begin
      exc_q <= 1'b1;
    end else if (stat_wr && pwdata[SCF_STAT_EXC]) begin
      exc_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_pulse_q <= 1'b0;
    end else begin
      exc_pulse_q <= exc_set;
    end
  end

  // ----------------------------------------------------------------------
  // field addressing
  // ----------------------------------------------------------------------
  logic [63:0] fld;
  logic [MW-1:0] ea_idx;
  logic [MW-1:0] ch_idx;
  logic [1:0] ch_lane;
  logic [4:0] ch_sh;
  logic [7:0] ch_val;
  logic [31:0] ch_word;
  logic [31:0] addsrc;
  logic [31:0] fa_sum;

  assign fld = fld_q[cmd.fsel];
  assign ea_idx = opnd_q[MW-1:0];
  assign ch_idx = fld[SCF_OFS_LO+MW-1:SCF_OFS_LO];
  assign ch_lane = fld[SCF_BIT_HI:SCF_BIT_HI-1];
  assign ch_sh = {~ch_lane, 3'b000};
  assign ch_val = 8'(mem_q[ch_idx] >> ch_sh);
  assign ch_word = (mem_q[ch_idx] & ~(32'h0000_00ff << ch_sh)) |
                   (32'(prim_q[7:0]) << ch_sh);
  assign addsrc = cmd.op == OP_ADD_LONG_TO_FIELD_ADDRESS ? {prim_q, sec_q} : gr_q[cmd.rsel];
  assign fa_sum = fld[SCF_SEG_HI:SCF_BIT_LO] + addsrc;

  // ----------------------------------------------------------------------
  // register file and memory
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= SCF_WORD_RST;
      prim_q <= 16'h0000;
      sec_q <= 16'h0000;
      ext_q <= SCF_WORD_RST;
      opnd_q <= SCF_WORD_RST;
      for (int i = 0; i < NUM_GR; i++) begin
        gr_q[i] <= SCF_WORD_RST;
      end
      for (int i = 0; i < 2; i++) begin
        fld_q[i] <= SCF_FLD_RST;
      end
      for (int i = 0; i < MEM_WORDS; i++) begin
        mem_q[i] <= SCF_WORD_RST;
      end
    end else if (exec) begin
      cmd_q <= pwdata;
      case (cmd.op)
        OP_SHIFT: begin
          if (cmd.tgt_long) begin
            {prim_q, sec_q} <= sh_res;
          end else begin
            gr_q[cmd.rsel] <= sh_res;
          end
        end
        OP_CLEAR_PRIMARY_HIGH_BYTE: prim_q[15:8] <= 8'h00;
        OP_CLEAR_PRIMARY_LOW_BYTE: prim_q[7:0] <= 8'h00;
        OP_ZERO_REG_TOP_BYTE: gr_q[cmd.rsel][31:24] <= 8'h00;
        OP_ZERO_REG_SECOND_BYTE: gr_q[cmd.rsel][23:16] <= 8'h00;
        OP_ZERO_UPPER_HALFWORD: gr_q[cmd.rsel][31:16] <= 16'h0000;
        OP_ZERO_LOWER_HALFWORD: gr_q[cmd.rsel][15:0] <= 16'h0000;
        OP_ZERO_WHOLE_REGISTER: gr_q[cmd.rsel] <= 32'h0000_0000;
        OP_ZERO_PRIMARY_ACC: prim_q <= 16'h0000;
        OP_ZERO_SECONDARY_REG: sec_q <= 16'h0000;
        OP_ZERO_EXTENSION_REG: ext_q <= 32'h0000_0000;
        OP_ZERO_LONG_ACC: begin
          prim_q <= 16'h0000;
          sec_q <= 16'h0000;
        end
        OP_ZERO_LONG_AND_EXTENSION: begin
          prim_q <= 16'h0000;
          sec_q <= 16'h0000;
          ext_q <= 32'h0000_0000;
        end
        OP_ZERO_MEMORY_WORD: mem_q[ea_idx] <= 32'h0000_0000;
        OP_ZERO_MEMORY_HALF: begin
          if (cmd.half_low) begin
            mem_q[ea_idx][15:0] <= 16'h0000;
          end else begin
            mem_q[ea_idx][31:16] <= 16'h0000;
          end
        end
        OP_ADD_LONG_TO_FIELD_ADDRESS, OP_ADD_REG_TO_FIELD_ADDRESS: begin
          fld_q[cmd.fsel][SCF_SEG_HI:SCF_BIT_LO] <= fa_sum;
        end
        OP_EFF_ADDR_TO_FIELD_ADDRESS: begin
          fld_q[cmd.fsel][SCF_SEG_HI:SCF_OFS_LO] <= opnd_q[27:0];
          fld_q[cmd.fsel][SCF_BIT_HI:SCF_BIT_LO] <= 4'h0;
        end
        OP_STORE_FIELD_ADDRESS: begin
          mem_q[ea_idx] <= fld[63:32];
          mem_q[MW'(ea_idx + 1'b1)] <= fld[31:0] & SCF_FLD_MASK[31:0];
        end
        OP_LOAD_LENGTH_IMMEDIATE: begin
          fld_q[cmd.fsel][SCF_LEN_HI:SCF_LEN_LO] <= opnd_q[SCF_LEN_W-1:0];
        end
        OP_LOAD_CHAR_FROM_FIELD: prim_q <= {8'h00, ch_val};
        OP_STORE_CHAR_TO_FIELD: mem_q[ch_idx] <= ch_word;
        OP_LENGTH_TO_LONG_ACC: begin
          {prim_q, sec_q} <= {11'h000, fld[SCF_LEN_HI:SCF_LEN_LO]};
        end
        OP_LENGTH_TO_GENERAL_REG: begin
          gr_q[cmd.rsel] <= {11'h000, fld[SCF_LEN_HI:SCF_LEN_LO]};
        end
        OP_LONG_ACC_TO_LENGTH: begin
          fld_q[cmd.fsel][SCF_LEN_HI:SCF_LEN_LO] <= {prim_q[4:0], sec_q};
        end
        OP_GENERAL_REG_TO_LENGTH: begin
          fld_q[cmd.fsel][SCF_LEN_HI:SCF_LEN_LO] <= gr_q[cmd.rsel][SCF_LEN_W-1:0];
        end
        default: begin
        end
      endcase
    end else if (wr_done) begin
      if (paddr == SCF_PRIM_OFF) begin
        prim_q <= pwdata[15:0];
      end else if (paddr == SCF_SEC_OFF) begin
        sec_q <= pwdata[15:0];
      end else if (paddr == SCF_EXT_OFF) begin
        ext_q <= pwdata;
      end else if (paddr == SCF_OPND_OFF) begin
        opnd_q <= pwdata;
      end else if (paddr[7:5] == SCF_GR_BASE[7:5]) begin
        gr_q[paddr[4:2]] <= pwdata;
      end else if (paddr[7:4] == SCF_FLD_BASE[7:4]) begin
        // halves written separately; must-be-zero bits kept clear
        if (paddr[2]) begin
          fld_q[paddr[3]][31:0] <= pwdata & SCF_FLD_MASK[31:0];
        end else begin
          fld_q[paddr[3]][63:32] <= pwdata & SCF_FLD_MASK[63:32];
        end
      end else if (paddr[7] && 32'(paddr[6:2]) < MEM_WORDS) begin
        mem_q[paddr[MW+1:2]] <= pwdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign carry_bit = carry_q;
  assign link_bit = link_q;
  assign int_exception = exc_pulse_q;

endmodule

/* tb/scf_datapath_chk.sv */
// port checker for the shift, clear and field datapath
`timescale 1ns/100ps
module scf_datapath_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic carry_bit,
  input wire logic link_bit,
  input wire logic int_exception
);
  // ----------------------------------------------------------------------
  // decode of completed transfers
  // ----------------------------------------------------------------------
  wire logic done = psel && penable && pready;
  wire logic cmdw = done && pwrite && (paddr[7:2] == 6'h00);
  wire logic statw = done && pwrite && (paddr[7:2] == 6'h01);
  wire logic shcmd = cmdw && (pwdata[5:0] == 6'h01) && (pwdata[24:20] != 5'h00);
  wire logic ovfc = shcmd && (pwdata[17:16] == 2'h1) && pwdata[15];
  wire logic unm = (paddr[7:3] == 5'h03) || (paddr[7:4] == 4'h5) || (paddr[7:5] == 3'h3)
    || (paddr[7:6] == 2'h3);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_shift_flags:
  assert property (shcmd |=> carry_bit == link_bit) else $error("carry and link differ");
  a_exc_cause:
  assert property (int_exception |-> $past(ovfc) || $past(ovfc, 2))
    else $error("exception without left arithmetic shift");
  a_exc_pulse:
  assert property (int_exception |=> !int_exception) else $error("exception not a pulse");
  a_exc_none:
  assert property (shcmd && !ovfc |=> !int_exception ##1 !int_exception)
    else $error("exception after plain shift");
  a_flags_hold:
  assert property (!(statw || shcmd) |=> $stable(carry_bit) && $stable(link_bit))
    else $error("flags moved without a shift");
  a_rdy_wait:
  assert property ($rose(penable) && psel |-> !pready ##1 pready) else $error("ready timing");
  a_rdy_pulse:
  assert property (pready |=> !pready) else $error("ready held too long");
  a_rdy_in_xfer:
  assert property (pready |-> psel && penable) else $error("ready outside access");
  a_err_quiet:
  assert property (pslverr |-> pready && prdata == 32'h0) else $error("error data not zero");
  a_map_err:
  assert property (pready |-> pslverr == unm) else $error("error flag against address map");
endmodule

bind scf_datapath scf_datapath_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .carry_bit(carry_bit), .link_bit(link_bit), .int_exception(int_exception)
);

/* tb/scf_datapath_test.sv */
// self-checking testbench of the shift, clear and field datapath
`timescale 1ns/100ps
module scf_datapath_test;
  import scf_pkg::*;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  localparam logic [7:0] GR3 = SCF_GR_BASE + 8'h0c;
  localparam logic [7:0] FHI = SCF_FLD_BASE;
  localparam logic [7:0] FLO = SCF_FLD_BASE + 8'h04;
  localparam logic [31:0] VA = 32'h0000_beef;
  localparam logic [31:0] VB = 32'h0000_cafe;
  localparam logic [31:0] VE = 32'hface_d00d;
  localparam logic [31:0] VG = 32'hdead_beef;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, carry_bit, link_bit, int_exception;
  logic [31:0] exc_n = 32'h0;
  int err_total = 0;
  int n_compared = 0;

  scf_datapath #(.MEM_WORDS(16), .NUM_GR(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .carry_bit(carry_bit), .link_bit(link_bit), .int_exception(int_exception)
  );

  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (int_exception === 1'b1) exc_n <= exc_n + 32'h1;
  end

  // ----------------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, g, x);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    q = prdata;
    e = pslverr;
    if (n == 40) chk(32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = '1);
    logic [31:0] q;
    logic e;
    xfer(1'b0, a, 32'h0, q, e);
    chk(q & m, x);
  endtask

  task automatic cmd(input scf_op_e o, input logic h, t, l, input scf_shift_e k,
                     input logic [4:0] c);
    scf_cmd_s w;
    w = '0;
    w.op = o;
    w.rsel = 3'd3;
    w.half_low = h;
    w.tgt_long = t;
    w.left = l;
    w.kind = k;
    w.cnt = c;
    wr(SCF_CMD_OFF, w);
  endtask

  task automatic op(input scf_op_e o);
    cmd(o, 1'b0, 1'b0, 1'b0, SH_LOGIC, 5'h0);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reg;
    logic [31:0] q;
    logic e;
    rd(SCF_STAT_OFF, 32'h0);
    wr(SCF_FLD_BASE + 8'h08, 32'hffff_ffff);
    rd(FHI, 32'h0);
    rd(SCF_FLD_BASE + 8'h08, 32'h6fff_ffff);
    rd(SCF_MEM_BASE + 8'h3c, 32'h0);
    xfer(1'b1, 8'h18, 32'hffff_ffff, q, e);
    chk({31'h0, e}, 32'h1);
    xfer(1'b0, 8'h50, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
  endtask

  task automatic sh(input logic [31:0] v, input scf_shift_e k, input logic l, t,
                    input logic [4:0] c, input logic [31:0] x, input logic [2:0] s, m);
    logic [31:0] e0;
    wr(SCF_STAT_OFF, {30'h1, ~s[1:0]});
    if (t) begin
      wr(SCF_PRIM_OFF, {16'h0, v[31:16]});
      wr(SCF_SEC_OFF, {16'h0, v[15:0]});
    end else begin
      wr(GR3, v);
    end
    e0 = exc_n;
    cmd(OP_SHIFT, 1'b0, t, l, k, c);
    if (t) begin
      rd(SCF_PRIM_OFF, {16'h0, x[31:16]});
      rd(SCF_SEC_OFF, {16'h0, x[15:0]});
    end else begin
      rd(GR3, x);
    end
    rd(SCF_STAT_OFF, {29'h0, s}, {29'h0, m});
    if (m[0]) chk({30'h0, link_bit, carry_bit}, {30'h0, s[1:0]});
    chk(exc_n - e0, {31'h0, s[2]});
  endtask

  task automatic clr(input scf_op_e o, input logic [31:0] a, b, e, g);
    wr(SCF_PRIM_OFF, VA);
    wr(SCF_SEC_OFF, VB);
    wr(SCF_EXT_OFF, VE);
    wr(GR3, VG);
    op(o);
    rd(SCF_PRIM_OFF, a);
    rd(SCF_SEC_OFF, b);
    rd(SCF_EXT_OFF, e);
    rd(GR3, g);
  endtask

  task automatic zm(input logic h, input scf_op_e o, input logic [31:0] x);
    wr(SCF_MEM_BASE + 8'h14, 32'hffff_ffff);
    wr(SCF_OPND_OFF, 32'h5);
    cmd(o, h, 1'b0, 1'b0, SH_LOGIC, 5'h0);
    rd(SCF_MEM_BASE + 8'h14, x);
  endtask

  task automatic t_shift;
    sh(32'h1800_0001, SH_LOGIC, 1'b1, 1'b0, 5'h4, 32'h8000_0010, 3'b011, 3'b111);
    sh(32'h8000_0004, SH_LOGIC, 1'b0, 1'b0, 5'h3, 32'h1000_0000, 3'b011, 3'b111);
    sh(32'h8000_0070, SH_ARITH, 1'b0, 1'b0, 5'h4, 32'hf800_0007, 3'b000, 3'b111);
    sh(32'h4000_0001, SH_ARITH, 1'b1, 1'b0, 5'h1, 32'h8000_0002, 3'b100, 3'b100);
    sh(32'h0000_0003, SH_ARITH, 1'b1, 1'b0, 5'h2, 32'h0000_000c, 3'b000, 3'b100);
    sh(32'h0000_0009, SH_ROT, 1'b0, 1'b0, 5'h4, 32'h9000_0000, 3'b011, 3'b111);
    sh(32'hab34_5678, SH_ROT, 1'b1, 1'b1, 5'h8, 32'h3456_78ab, 3'b011, 3'b111);
  endtask

  task automatic t_clear;
    wr(SCF_STAT_OFF, 32'h7);
    clr(OP_CLEAR_PRIMARY_HIGH_BYTE, 32'h00ef, VB, VE, VG);
    clr(OP_CLEAR_PRIMARY_LOW_BYTE, 32'hbe00, VB, VE, VG);
    clr(OP_ZERO_REG_TOP_BYTE, VA, VB, VE, 32'h00ad_beef);
    clr(OP_ZERO_REG_SECOND_BYTE, VA, VB, VE, 32'hde00_beef);
    clr(OP_ZERO_UPPER_HALFWORD, VA, VB, VE, 32'h0000_beef);
    clr(OP_ZERO_LOWER_HALFWORD, VA, VB, VE, 32'hdead_0000);
    clr(OP_ZERO_WHOLE_REGISTER, VA, VB, VE, 32'h0);
    clr(OP_ZERO_PRIMARY_ACC, 32'h0, VB, VE, VG);
    clr(OP_ZERO_SECONDARY_REG, VA, 32'h0, VE, VG);
    clr(OP_ZERO_EXTENSION_REG, VA, VB, 32'h0, VG);
    clr(OP_ZERO_LONG_ACC, 32'h0, 32'h0, VE, VG);
    clr(OP_ZERO_LONG_AND_EXTENSION, 32'h0, 32'h0, 32'h0, VG);
    zm(1'b0, OP_ZERO_MEMORY_WORD, 32'h0);
    zm(1'b1, OP_ZERO_MEMORY_HALF, 32'hffff_0000);
    zm(1'b0, OP_ZERO_MEMORY_HALF, 32'h0000_ffff);
    rd(SCF_STAT_OFF, 32'h3);
    chk({30'h0, link_bit, carry_bit}, 32'h3);
  endtask

  task automatic t_field;
    wr(FHI, 32'hffff_ffff);
    wr(FLO, 32'hffff_ffff);
    rd(FHI, 32'h6fff_ffff);
    rd(FLO, 32'hf01f_ffff);
    wr(FHI, 32'h2001_0002);
    wr(FLO, 32'h1000_0000);
    rd(FHI, 32'h2001_0002);
    wr(SCF_OPND_OFF, 32'hffe1_2345);
    op(OP_LOAD_LENGTH_IMMEDIATE);
    rd(FLO, 32'h1001_2345);
    op(OP_LENGTH_TO_GENERAL_REG);
    rd(GR3, 32'h0001_2345);
    op(OP_LENGTH_TO_LONG_ACC);
    rd(SCF_PRIM_OFF, 32'h0001);
    rd(SCF_SEC_OFF, 32'h2345);
    wr(GR3, 32'hffff_ffff);
    op(OP_GENERAL_REG_TO_LENGTH);
    rd(FLO, 32'h101f_ffff);
    wr(SCF_PRIM_OFF, 32'h0);
    wr(SCF_SEC_OFF, 32'h42);
    op(OP_LONG_ACC_TO_LENGTH);
    rd(FLO, 32'h1000_0042);
    wr(GR3, 32'h10);
    op(OP_ADD_REG_TO_FIELD_ADDRESS);
    rd(FHI, 32'h2001_0003);
    wr(SCF_SEC_OFF, 32'h20);
    op(OP_ADD_LONG_TO_FIELD_ADDRESS);
    rd(FHI, 32'h2001_0005);
    wr(SCF_OPND_OFF, 32'h0abc_1234);
    op(OP_EFF_ADDR_TO_FIELD_ADDRESS);
    rd(FHI, 32'h2abc_1234);
    rd(FLO, 32'h0000_0042);
    wr(SCF_OPND_OFF, 32'h3);
    op(OP_STORE_FIELD_ADDRESS);
    rd(SCF_MEM_BASE + 8'h0c, 32'h2abc_1234);
    rd(SCF_MEM_BASE + 8'h10, 32'h0000_0042);
    wr(FLO, 32'h8000_0042);
    wr(SCF_PRIM_OFF, 32'h00a5);
    op(OP_STORE_CHAR_TO_FIELD);
    rd(SCF_MEM_BASE + 8'h10, 32'h0000_a542);
    wr(SCF_PRIM_OFF, 32'hffff);
    op(OP_LOAD_CHAR_FROM_FIELD);
    rd(SCF_PRIM_OFF, 32'h00a5);
    rd(SCF_STAT_OFF, 32'h3);
    chk({30'h0, link_bit, carry_bit}, 32'h3);
  endtask

  // ----------------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------------
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reg();
    t_shift();
    t_clear();
    t_field();
    final_report();
  end

  initial begin
    repeat (8000) @(posedge pclk);
    err_total++;
    final_report();
  end
endmodule
